// *** host_port_pkg.sv ***
/*
 constants shared by the fieldbus master end and the cpu controller end:
 bit map positions, buffer word addresses, timing and apb register offsets.
 assumes both ends run on one clock, i_mclk at 10 MHz.
*/
package host_port_pkg;
   // ----------------------------------------------------------------
   // bit map
   // ----------------------------------------------------------------
   localparam logic [15:0] MAP_START = 16'h0000;
   localparam int X_EXCH_STARTED = 0;
   localparam int X_TROUBLE = 1;
   localparam int X_CLEAR_DONE = 2;
   localparam int Y_EXCH_REQ = 0;
   localparam int Y_TROUBLE_RESET = 1;
   localparam int Y_CLEAR_REQ = 2;
   localparam int Y_TYPE_SEL = 3;
   localparam logic [31:0] Y_ALLOWED = 32'h0000000F;
   localparam logic [31:0] X_ALLOWED = 32'h00000007;
   // ----------------------------------------------------------------
   // buffer memory word addresses
   // ----------------------------------------------------------------
   localparam int BUF_WORDS = 2117;
   localparam logic [11:0] ADDR_TROUBLE = 12'h7F8;
   localparam logic [5:0] TROUBLE_LAST = 6'h27;
   localparam logic [11:0] ADDR_HOLDOFF = 12'h824;
   localparam logic [11:0] ADDR_EXT = 12'h830;
   localparam int EXT_WORDS = 15;
   localparam logic [11:0] ADDR_SLAVE = 12'h840;
   localparam logic [11:0] ADDR_SLAVE_END = 12'h844;
   localparam int SLAVE_BITS = 80;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int HOLDOFF_UNIT_NS = 1000000;
   localparam int HOLDOFF_TICK_CYC = HOLDOFF_UNIT_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // apb registers of the controller
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_BUF_ADDR = 8'h08;
   localparam logic [7:0] REG_BUF_DATA = 8'h0C;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam int IRQ_EXCH_UP = 0;
   localparam int IRQ_EXCH_DOWN = 1;
   localparam int IRQ_TROUBLE = 2;
   localparam int IRQ_CLEAR_DONE = 3;
   localparam int IRQ_BITS = 4;
endpackage

// *** host_port_if.sv ***
/*
 bit maps and buffer memory port between master end and cpu end.
 assumes one common clock; the bench joins both ends through it.
*/
`timescale 1ns/1ps
interface host_port_if;
   logic [31:0] x_bits;
   logic [31:0] y_bits;
   logic [11:0] buf_addr;
   logic buf_we;
   logic [15:0] buf_wdata;
   logic [15:0] buf_rdata;
   modport dev
   (
      input y_bits, buf_addr, buf_we, buf_wdata,
      output x_bits, buf_rdata
   );
   modport cpu
   (
      input x_bits, buf_rdata,
      output y_bits, buf_addr, buf_we, buf_wdata
   );
endinterface

// *** trouble_holdoff.sv ***
/*
 hold-off timer: counts time units while exchange runs.
 assumes i_limit is stable while i_run is high.
*/
`timescale 1ns/1ps
module trouble_holdoff #(
   parameter int TICK_CYC = host_port_pkg::HOLDOFF_TICK_CYC
)(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [15:0] i_limit,
   output logic o_elapsed
);
   import host_port_pkg::*;
   logic [31:0] tick_ff;
   logic [15:0] units_ff;
   logic tick_done;

   assign tick_done = (tick_ff == 32'(TICK_CYC - 1));

   always_ff @(posedge i_mclk)
   begin
      if (i_rst || !i_run)
         tick_ff <= 32'h00000000;
      else if (tick_done)
         tick_ff <= 32'h00000000;
      else
         tick_ff <= tick_ff + 32'h00000001;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst || !i_run)
         units_ff <= 16'h0000;
      else if (tick_done && units_ff != 16'hFFFF)
         units_ff <= units_ff + 16'h0001;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         o_elapsed <= 1'b0;
      else
         o_elapsed <= i_run && (units_ff >= i_limit);
   end
endmodule

// *** fieldbus_master_end.sv ***
/*
 fieldbus master end: exchange handshake, trouble detection, trouble
 logging into buffer memory, slave status words, response error light.
 assumes the cpu end keeps its own obligations and the fieldbus engine
 reports exchange state on the same clock; slave failures are async.
*/
// Behaviour
// - input map to cpu, output map from cpu
// - output bits: request, reset, clear, type
// - cpu never sets prohibited bits
// - started flag rises once exchange runs
// - started flag drops on listed stop causes
// - cpu interlocks data reads on both flags
// - cpu loads initial outputs before request
// - trouble flagged only after hold-off elapses
// - record and extended record written on detection
// - detection sets slave bit and indicator
// - reset or all failures gone clears trouble
// - cpu drops reset after flag seen low
// - new failure during reset re-raises flag
// - clear acts on clear request rising edge
// - cleared persistent failure never re-detected
// - slave bits self clear, reset keeps them
`timescale 1ns/1ps
module fieldbus_master_end #(
   parameter int N_STATIONS = 80,
   parameter int TICK_CYC = host_port_pkg::HOLDOFF_TICK_CYC
)(
   input wire logic i_mclk,
   input wire logic i_rst,
   host_port_if.dev port,
   input wire logic i_exch_running,
   input wire logic i_exch_error,
   input wire logic i_param_download,
   input wire logic i_mode_change,
   input wire logic i_stop_on_slave_err,
   input wire logic [N_STATIONS-1:0] i_slave_fail,
   output logic o_response_error_indicator
);
   import host_port_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0] mem_ff [0:BUF_WORDS-1];
   logic [N_STATIONS-1:0] fail_meta_ff;
   logic [N_STATIONS-1:0] fail_ff;
   logic [N_STATIONS-1:0] seen_ff;
   logic [N_STATIONS-1:0] new_fail;
   logic exch_ff;
   logic nxt_exch;
   logic trouble_ff;
   logic clear_done_ff;
   logic reset_prev_ff;
   logic clear_prev_ff;
   logic req_prev_ff;
   logic type_fixed_ff;
   logic [5:0] ptr_ff;
   logic full_ff;
   logic [15:0] count_ff;
   logic [15:0] rdata_ff;
   logic elapsed;
   logic detect;
   logic reset_rise;
   logic clear_rise;
   logic log_ok;
   logic [SLAVE_BITS-1:0] slave_vec;
   logic [2:0] slave_idx;
   logic [6:0] station;

   function automatic logic [6:0] first_set(input logic [SLAVE_BITS-1:0] v);
      logic [6:0] r;
      r = 7'h00;
      for (int i = SLAVE_BITS - 1; i >= 0; i--)
      begin
         if (v[i])
            r = 7'(i);
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // failure inputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         fail_meta_ff <= '0;
         fail_ff <= '0;
      end
      else
      begin
         fail_meta_ff <= i_slave_fail;
         fail_ff <= fail_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // exchange handshake
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_exch = port.y_bits[Y_EXCH_REQ] && i_exch_running;
      if (i_exch_error || i_param_download || i_mode_change)
         nxt_exch = 1'b0;
      if (i_stop_on_slave_err && (|fail_ff))
         nxt_exch = 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         exch_ff <= 1'b0;
      else
         exch_ff <= nxt_exch;
   end

   // ----------------------------------------------------------------
   // trouble detection
   // ----------------------------------------------------------------
   trouble_holdoff #(
      .TICK_CYC(TICK_CYC)
   ) u_holdoff (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_run(exch_ff),
      .i_limit(mem_ff[ADDR_HOLDOFF]),
      .o_elapsed(elapsed)
   );

   assign new_fail = fail_ff & ~seen_ff;
   assign detect = elapsed && exch_ff && (|new_fail);
   assign reset_rise = port.y_bits[Y_TROUBLE_RESET] && !reset_prev_ff;
   assign clear_rise = port.y_bits[Y_CLEAR_REQ] && !clear_prev_ff;
   assign station = first_set(SLAVE_BITS'(new_fail));

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         reset_prev_ff <= 1'b0;
         clear_prev_ff <= 1'b0;
         req_prev_ff <= 1'b0;
      end
      else
      begin
         reset_prev_ff <= port.y_bits[Y_TROUBLE_RESET];
         clear_prev_ff <= port.y_bits[Y_CLEAR_REQ];
         req_prev_ff <= port.y_bits[Y_EXCH_REQ];
      end
   end

   // a failure stays seen until it goes away, reset or not
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         seen_ff <= '0;
      else if (detect)
         seen_ff <= fail_ff;
      else
         seen_ff <= fail_ff & seen_ff;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         trouble_ff <= 1'b0;
      else if (detect)
         trouble_ff <= 1'b1;
      else if (reset_rise || !(|fail_ff))
         trouble_ff <= 1'b0;
   end

   assign o_response_error_indicator = trouble_ff;

   // ----------------------------------------------------------------
   // trouble area control
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         clear_done_ff <= 1'b0;
      else if (!port.y_bits[Y_CLEAR_REQ])
         clear_done_ff <= 1'b0;
      else if (clear_rise)
         clear_done_ff <= 1'b1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         type_fixed_ff <= 1'b0;
      else if ((port.y_bits[Y_EXCH_REQ] && !req_prev_ff) || port.y_bits[Y_CLEAR_REQ])
         type_fixed_ff <= port.y_bits[Y_TYPE_SEL];
   end

   assign log_ok = !type_fixed_ff || !full_ff;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst || clear_rise)
      begin
         ptr_ff <= 6'h00;
         full_ff <= 1'b0;
      end
      else if (detect && log_ok)
      begin
         ptr_ff <= (ptr_ff == TROUBLE_LAST) ? 6'h00 : ptr_ff + 6'h01;
         if (ptr_ff == TROUBLE_LAST)
            full_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         count_ff <= 16'h0000;
      else if (detect && count_ff != 16'hFFFF)
         count_ff <= count_ff + 16'h0001;
   end

   // ----------------------------------------------------------------
   // buffer memory
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < BUF_WORDS; i++)
            mem_ff[i] <= 16'h0000;
      end
      else
      begin
         if (port.buf_we && (port.buf_addr < ADDR_TROUBLE || port.buf_addr == ADDR_HOLDOFF))
            mem_ff[port.buf_addr] <= port.buf_wdata;
         if (clear_rise)
         begin
            for (int i = 0; i <= int'(TROUBLE_LAST); i++)
               mem_ff[int'(ADDR_TROUBLE) + i] <= 16'h0000;
            for (int i = 0; i < EXT_WORDS; i++)
               mem_ff[int'(ADDR_EXT) + i] <= 16'h0000;
         end
         if (detect && log_ok)
            mem_ff[ADDR_TROUBLE + {6'h00, ptr_ff}] <= {9'h000, station};
         if (detect)
         begin
            mem_ff[ADDR_EXT] <= count_ff + 16'h0001;
            mem_ff[ADDR_EXT + 12'h001] <= {9'h000, station};
         end
      end
   end

   // ----------------------------------------------------------------
   // buffer read and flag map
   // ----------------------------------------------------------------
   assign slave_vec = SLAVE_BITS'(fail_ff & seen_ff);
   assign slave_idx = 3'(port.buf_addr - ADDR_SLAVE);

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         rdata_ff <= 16'h0000;
      else if (port.buf_addr >= ADDR_SLAVE && port.buf_addr <= ADDR_SLAVE_END)
         rdata_ff <= slave_vec[16*slave_idx +: 16];
      else if (port.buf_addr < ADDR_SLAVE)
         rdata_ff <= mem_ff[port.buf_addr];
      else
         rdata_ff <= 16'h0000;
   end

   assign port.buf_rdata = rdata_ff;

   always_comb
   begin
      port.x_bits = 32'h00000000;
      port.x_bits[X_EXCH_STARTED] = exch_ff;
      port.x_bits[X_TROUBLE] = trouble_ff;
      port.x_bits[X_CLEAR_DONE] = clear_done_ff;
   end
endmodule

// *** cpu_ctrl_end.sv ***
/*
 cpu end: drives the output bit map and the buffer port from apb
 registers, reports the input bit map and raises one interrupt.
 assumes the master end on the same clock behind host_port_if.
*/
`timescale 1ns/1ps
module cpu_ctrl_end (
   input wire logic i_mclk,
   input wire logic i_rst,
   host_port_if.cpu port,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq
);
   import host_port_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [3:0] ctrl_ff;
   logic trouble_reset_ff;
   logic init_ff;
   logic [11:0] addr_ff;
   logic we_ff;
   logic [15:0] wdata_ff;
   logic [IRQ_BITS-1:0] irq_stat_ff;
   logic [IRQ_BITS-1:0] irq_mask_ff;
   logic [31:0] prdata_ff;
   logic [31:0] x_prev_ff;
   logic [IRQ_BITS-1:0] events;
   logic [31:0] nxt_prdata;
   logic access;
   logic mapped;
   logic io_ok;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign access = i_psel && i_penable;
   assign mapped = (i_paddr <= REG_IRQ_MASK) && (i_paddr[1:0] == 2'b00);
   assign o_pready = access;
   assign o_pslverr = access && !mapped;
   assign io_ok = port.y_bits[Y_EXCH_REQ] && port.x_bits[X_EXCH_STARTED];

   always_comb
   begin
      nxt_prdata = 32'h00000000;
      unique case (i_paddr)
         REG_CTRL: nxt_prdata = {28'h0000000, ctrl_ff};
         REG_STAT: nxt_prdata = port.x_bits & X_ALLOWED;
         REG_BUF_ADDR: nxt_prdata = {20'h00000, addr_ff};
         REG_BUF_DATA:
         begin
            if (addr_ff >= ADDR_TROUBLE || io_ok)
               nxt_prdata = {16'h0000, port.buf_rdata};
         end
         REG_IRQ_STAT: nxt_prdata = {28'h0000000, irq_stat_ff};
         REG_IRQ_MASK: nxt_prdata = {28'h0000000, irq_mask_ff};
         default: nxt_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         prdata_ff <= 32'h00000000;
      else if (i_psel && !i_penable)
         prdata_ff <= nxt_prdata;
   end

   assign o_prdata = prdata_ff;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ctrl_ff <= 4'h0;
         addr_ff <= 12'h000;
         irq_mask_ff <= '0;
      end
      else if (access && i_pwrite)
      begin
         if (i_paddr == REG_CTRL)
            ctrl_ff <= i_pwdata[3:0];
         if (i_paddr == REG_BUF_ADDR)
            addr_ff <= i_pwdata[11:0];
         if (i_paddr == REG_IRQ_MASK)
            irq_mask_ff <= i_pwdata[IRQ_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // buffer writes
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         we_ff <= 1'b0;
         wdata_ff <= 16'h0000;
      end
      else
      begin
         we_ff <= access && i_pwrite && i_paddr == REG_BUF_DATA;
         if (access && i_pwrite && i_paddr == REG_BUF_DATA)
            wdata_ff <= i_pwdata[15:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         init_ff <= 1'b0;
      else if (we_ff && addr_ff < ADDR_TROUBLE)
         init_ff <= 1'b1;
   end

   assign port.buf_addr = addr_ff;
   assign port.buf_we = we_ff;
   assign port.buf_wdata = wdata_ff;

   // ----------------------------------------------------------------
   // output bit map
   // ----------------------------------------------------------------
   // reset is held until the trouble flag is seen low
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         trouble_reset_ff <= 1'b0;
      else if (ctrl_ff[Y_TROUBLE_RESET])
         trouble_reset_ff <= 1'b1;
      else if (!port.x_bits[X_TROUBLE])
         trouble_reset_ff <= 1'b0;
   end

   always_comb
   begin
      port.y_bits = 32'h00000000;
      port.y_bits[Y_EXCH_REQ] = ctrl_ff[Y_EXCH_REQ] && init_ff;
      port.y_bits[Y_TROUBLE_RESET] = trouble_reset_ff;
      port.y_bits[Y_CLEAR_REQ] = ctrl_ff[Y_CLEAR_REQ];
      port.y_bits[Y_TYPE_SEL] = ctrl_ff[Y_TYPE_SEL];
      port.y_bits = port.y_bits & Y_ALLOWED;
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         x_prev_ff <= 32'h00000000;
      else
         x_prev_ff <= port.x_bits;
   end

   assign events[IRQ_EXCH_UP] = port.x_bits[X_EXCH_STARTED] && !x_prev_ff[X_EXCH_STARTED];
   assign events[IRQ_EXCH_DOWN] = !port.x_bits[X_EXCH_STARTED] && x_prev_ff[X_EXCH_STARTED];
   assign events[IRQ_TROUBLE] = port.x_bits[X_TROUBLE] && !x_prev_ff[X_TROUBLE];
   assign events[IRQ_CLEAR_DONE] = port.x_bits[X_CLEAR_DONE] && !x_prev_ff[X_CLEAR_DONE];

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         irq_stat_ff <= '0;
      else if (access && !i_pwrite && i_paddr == REG_IRQ_STAT)
         irq_stat_ff <= events;
      else
         irq_stat_ff <= irq_stat_ff | events;
   end

   assign o_irq = |(irq_stat_ff & irq_mask_ff);
endmodule

// *** host_port_props.sv ***
/*
 checker on the bit maps between master end and cpu end.
 assumes one clock, i_mclk, and sync active-high i_rst.
*/
`timescale 1ns/1ps
module host_port_props (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [31:0] x_bits,
   input wire logic [31:0] y_bits,
   input wire logic i_exch_running,
   input wire logic i_exch_error,
   input wire logic i_param_download,
   input wire logic i_mode_change,
   input wire logic i_stop_on_slave_err,
   input wire logic o_response_error_indicator
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic exch_ok;
   assign exch_ok = y_bits[0] & i_exch_running & ~i_exch_error & ~i_param_download
      & ~i_mode_change;
   sequence s_start;
      exch_ok && !i_stop_on_slave_err;
   endsequence
   sequence s_new_trouble;
      $rose(x_bits[1]);
   endsequence
   a_prohib_y_bits: assert property (y_bits[31:4] == 28'h0)
      else $error("prohibited output bit set");
   a_prohib_x_bits: assert property (x_bits[31:3] == 29'h0)
      else $error("prohibited input bit set");
   a_exch_rise: assert property (s_start |=> x_bits[0])
      else $error("started flag missing");
   a_exch_cause: assert property ($rose(x_bits[0]) |-> $past(exch_ok))
      else $error("started flag without cause");
   a_exch_drop: assert property (!exch_ok |=> !x_bits[0])
      else $error("started flag kept after stop cause");
   a_trouble_exch: assert property (s_new_trouble |-> $past(x_bits[0]))
      else $error("trouble flagged while exchange idle");
   a_led_follows: assert property (o_response_error_indicator == x_bits[1])
      else $error("indicator differs from trouble flag");
   a_reset_release: assert property ($fell(y_bits[1]) |-> !$past(x_bits[1]))
      else $error("trouble reset dropped while flag high");
endmodule

// *** tb_top.sv ***
/*
 bench: both ends joined by host_port_if, cpu end driven over apb.
 assumes the design files and host_port_pkg compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   import host_port_pkg::*;
   localparam int TICK = 4;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, led;
   logic run = 1'b0, err = 1'b0, dl = 1'b0, mc = 1'b0, stop = 1'b0;
   logic [79:0] fail = 80'h0;
   logic [32:0] expq[$];
   logic [31:0] seed = 32'h34;
   logic [15:0] d;
   int st;
   int n_errors = 0;
   int tests_run = 0;
   always #50 i_mclk = ~i_mclk;
   host_port_if hp ();
   fieldbus_master_end #(.N_STATIONS(80), .TICK_CYC(TICK)) fieldbus_master_end_inst (
      .i_mclk(i_mclk), .i_rst(i_rst), .port(hp), .i_exch_running(run),
      .i_exch_error(err), .i_param_download(dl), .i_mode_change(mc),
      .i_stop_on_slave_err(stop), .i_slave_fail(fail), .o_response_error_indicator(led));
   cpu_ctrl_end cpu_ctrl_end_inst (.i_mclk(i_mclk), .i_rst(i_rst), .port(hp),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_irq(irq));
   host_port_props host_port_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
      .x_bits(hp.x_bits), .y_bits(hp.y_bits), .i_exch_running(run), .i_exch_error(err),
      .i_param_download(dl), .i_mode_change(mc), .i_stop_on_slave_err(stop),
      .o_response_error_indicator(led));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge i_mclk);
      penable <= 1'b1;
      @(posedge i_mclk);
      while (pready !== 1'b1) @(posedge i_mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic rd_buf(input logic [11:0] a, input logic [15:0] e);
      apb(1'b1, REG_BUF_ADDR, {20'h0, a});
      repeat (2) @(posedge i_mclk);
      rd(REG_BUF_DATA, {17'h0, e});
   endtask
   task stop_test;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // read checker and watchdog
   // ----------------------------------------------------------------
   always @(posedge i_mclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         `CHK({pslverr, prdata}, expq.pop_front())
      end
   initial
   begin
      repeat (5000) @(posedge i_mclk);
      n_errors++;
      stop_test();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(REG_STAT, 33'h0);
      rd(8'h18, 33'h100000000);
      rd(REG_IRQ_MASK, 33'h0);
      apb(1'b1, REG_IRQ_MASK, 32'hF);
      $display("done: registers");
      d = 16'(xorshift());
      apb(1'b1, REG_BUF_ADDR, 32'h0);
      apb(1'b1, REG_BUF_DATA, {16'h0, d});
      apb(1'b1, REG_BUF_ADDR, {20'h0, ADDR_HOLDOFF});
      apb(1'b1, REG_BUF_DATA, 32'h5);
      rd_buf(12'h000, 16'h0);
      run <= 1'b1;
      apb(1'b1, REG_CTRL, 32'hFFF00001);
      fail[5] <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd(REG_STAT, 33'h1);
      rd_buf(12'h000, d);
      rd(REG_IRQ_STAT, 33'h1);
      repeat (30) @(posedge i_mclk);
      rd(REG_STAT, 33'h3);
      @(negedge i_mclk);
      `CHK(irq, 1'b1)
      `CHK(led, 1'b1)
      rd_buf(ADDR_TROUBLE, 16'h5);
      rd_buf(ADDR_EXT, 16'h1);
      rd_buf(12'h831, 16'h5);
      rd_buf(ADDR_SLAVE, 16'h0020);
      rd(REG_IRQ_STAT, 33'h4);
      @(negedge i_mclk);
      `CHK(irq, 1'b0)
      $display("done: detection");
      apb(1'b1, REG_CTRL, 32'h3);
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      `CHK(led, 1'b0)
      rd(REG_STAT, 33'h1);
      rd_buf(ADDR_SLAVE, 16'h0020);
      fail[9] <= 1'b1;
      repeat (6) @(posedge i_mclk);
      @(negedge i_mclk);
      `CHK(led, 1'b1)
      rd(REG_STAT, 33'h3);
      fail <= 80'h0;
      repeat (4) @(posedge i_mclk);
      rd(REG_STAT, 33'h1);
      rd_buf(ADDR_SLAVE, 16'h0);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b1, REG_IRQ_MASK, 32'h0);
      rd(REG_IRQ_STAT, 33'h4);
      $display("done: reset handshake");
      st = int'(xorshift() % 32'd80);
      fail[st] <= 1'b1;
      repeat (6) @(posedge i_mclk);
      rd(REG_STAT, 33'h3);
      @(negedge i_mclk);
      `CHK(irq, 1'b0)
      rd_buf(ADDR_SLAVE + 12'(st / 16), 16'(1 << (st % 16)));
      apb(1'b1, REG_CTRL, 32'h3);
      repeat (3) @(posedge i_mclk);
      rd(REG_STAT, 33'h1);
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (6) @(posedge i_mclk);
      rd(REG_STAT, 33'h1);
      rd(REG_IRQ_STAT, 33'h4);
      $display("done: persistent failure");
      apb(1'b1, REG_CTRL, 32'hD);
      rd(REG_STAT, 33'h5);
      rd_buf(ADDR_TROUBLE, 16'h0);
      rd_buf(ADDR_EXT, 16'h0);
      apb(1'b1, REG_CTRL, 32'h1);
      rd(REG_STAT, 33'h1);
      rd(REG_IRQ_STAT, 33'h8);
      $display("done: trouble area clear");
      for (int k = 0; k < 4; k++)
      begin
         {stop, mc, dl, err} <= 4'h1 << k;
         repeat (3) @(posedge i_mclk);
         rd(REG_STAT, 33'h0);
         {stop, mc, dl, err} <= 4'h0;
         repeat (3) @(posedge i_mclk);
         rd(REG_STAT, 33'h1);
      end
      apb(1'b1, REG_STAT, 32'hF);
      rd(REG_STAT, 33'h1);
      $display("done: stop causes");
      stop_test();
   end
endmodule
